/* cntc_pkg.sv */
/*
 * Shared constants and carriers for the channel oscillator tuning control bank.
 * Assumes an 8-bit register port driven by the serial control port core.
 */
package cntc_pkg;

    localparam int ADDR_W       = 12;
    localparam int DATA_W       = 8;
    localparam int MAX_CHANNELS = 8;
    localparam int WORD_BYTES   = 3;
    localparam int WORD_W       = 24;

    localparam logic [ADDR_W-1:0] PAGE_ADDR  = 12'h008;
    localparam logic [ADDR_W-1:0] CFG_ADDR   = 12'h130;
    localparam logic [ADDR_W-1:0] UPD_ADDR   = 12'h131;
    localparam logic [ADDR_W-1:0] WORD0_ADDR = 12'h132;
    localparam logic [ADDR_W-1:0] WORD1_ADDR = 12'h133;
    localparam logic [ADDR_W-1:0] WORD2_ADDR = 12'h134;

    localparam int CFG_DC_BIT       = 0;
    localparam int CFG_SIDEBAND_BIT = 1;
    localparam int CFG_MODULUS_BIT  = 2;
    localparam int CFG_OSC_EN_BIT   = 6;
    localparam int UPD_REQ_BIT      = 0;
    localparam int UPD_ACK_BIT      = 1;
    localparam int UPD_SYNC_BIT     = 2;

    localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 8'h7f;
    localparam logic [DATA_W-1:0] CFG_RESET      = 8'h00;
    localparam logic [DATA_W-1:0] PAGE_RESET     = 8'hff;
    localparam logic [WORD_W-1:0] WORD_RESET     = 24'h000000;

    localparam logic SIDEBAND_UPPER = 1'b0;
    localparam logic SIDEBAND_LOWER = 1'b1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } cntc_reg_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] cfg;
        logic              sync_sel;
        logic              req;
        logic              ack;
        logic              armed;
        logic [WORD_W-1:0] staged;
        logic [WORD_W-1:0] active;
        logic              load_pulse;
    } cntc_chan_s;

    typedef struct packed {
        logic              osc_enable;
        logic              modulus_enable;
        logic              sideband_select;
        logic              dc_tone_input_enable;
        logic [WORD_W-1:0] tuning_word;
        logic              osc_reset;
    } cntc_chan_ctl_s;

endpackage

/* cntc_bank.sv */
/*
 * Banked per-channel oscillator controls: config, staged tuning word, load handshake.
 * Assumes register accesses arrive as one-cycle strobes on mclk_in and that the
 * sync reference arrives asynchronously on a pin.
 */
// Notes on behaviour
// RQ1: Sideband bit: 0 upper, 1 lower flipped.
// RQ2: Dc enable feeds constant test tone input.
// RQ3: Sync select loads on next reference rise.
// RQ4: Acknowledge reads 1 once word loaded.
// RQ5: Only request rising edge loads word.
// RQ6: Word bytes stack low to high.
// RQ7: Plain mode frequency is rate times word/2^24.
// RQ8: Modulus mode adds delta over modulus.
// RQ9: Software keeps delta nonzero in modulus mode.
// RQ10: Page register selects addressed channel copies.
// RQ11: Software enables oscillator for complex modes.
// RQ12: Modulus enable picks plain or fractional.
// RQ13: New request clears acknowledge first.
`timescale 1ns/1ps

module cntc_bank #(
    parameter int NUM_CHANNELS = 3
) (
    input  wire logic                                     mclk_in,
    input  wire logic                                     resetn_in,
    input  wire cntc_pkg::cntc_reg_req_s                  reg_req_in,
    output logic [cntc_pkg::DATA_W-1:0]                   reg_rdata_out,
    input  wire logic                                     sync_ref_in,
    output cntc_pkg::cntc_chan_ctl_s [NUM_CHANNELS-1:0]   chan_ctl_out
);
    import cntc_pkg::*;

    // The page mask is one byte wide, so more channels cannot be addressed
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > MAX_CHANNELS) begin : g_bad_channels
        $error("NUM_CHANNELS out of range");
    end

    typedef struct packed {
        logic [DATA_W-1:0]                page;
        cntc_chan_s [NUM_CHANNELS-1:0]    ch;
        logic [2:0]                       sync_sh;
        logic                             sync_lvl;
        logic [DATA_W-1:0]                rdata;
    } cntc_state_s;

    cntc_state_s s_q;
    cntc_state_s s_d;

    // True for a write strobe aimed at one register address
    function automatic logic wr_hit(input cntc_reg_req_s     r,
                                    input logic [ADDR_W-1:0] a);
        return r.wr && (r.addr == a);
    endfunction

    function automatic logic rd_hit(input cntc_reg_req_s     r,
                                    input logic [ADDR_W-1:0] a);
        return r.rd && (r.addr == a);
    endfunction

    // Byte lane of a tuning word address, or -1 off the word
    function automatic int word_lane(input logic [ADDR_W-1:0] a);
        int lane;
        lane = -1;
        unique case (a)
            WORD0_ADDR: lane = 0;
            WORD1_ADDR: lane = 1;
            WORD2_ADDR: lane = 2;
            default: lane = -1;
        endcase
        return lane;
    endfunction

    // Only the low word bytes are kept; other lanes change nothing
    function automatic logic [WORD_W-1:0] put_byte(input logic [WORD_W-1:0] w,
                                                   input int                lane,
                                                   input logic [DATA_W-1:0] b);
        logic [WORD_W-1:0] n;
        n = w;
        if (lane >= 0 && lane < WORD_BYTES) begin
            n[lane*DATA_W +: DATA_W] = b;
        end
        return n;
    endfunction

    function automatic logic [DATA_W-1:0] get_byte(input logic [WORD_W-1:0] w,
                                                   input int                lane);
        logic [DATA_W-1:0] b;
        b = '0;
        if (lane >= 0 && lane < WORD_BYTES) begin
            b = w[lane*DATA_W +: DATA_W];
        end
        return b;
    endfunction

    // Last two stages agree, so the pin level is trusted
    function automatic logic sync_settled(input logic [2:0] sh);
        return sh[1] == sh[2];
    endfunction

    // Reads come from the lowest selected copy when several pages are set
    function automatic int first_sel(input logic [DATA_W-1:0] page);
        int idx;
        idx = 0;
        for (int k = NUM_CHANNELS - 1; k >= 0; k--) begin
            if (page[k]) begin
                idx = k;
            end
        end
        return idx;
    endfunction

    function automatic logic [DATA_W-1:0] read_chan(input cntc_chan_s c,
                                                    input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        unique case (a)
            CFG_ADDR: v = c.cfg & CFG_WRITE_MASK;
            UPD_ADDR: begin
                v[UPD_SYNC_BIT] = c.sync_sel;
                v[UPD_ACK_BIT]  = c.ack; // RQ4
                v[UPD_REQ_BIT]  = c.req;
            end
            WORD0_ADDR,
            WORD1_ADDR,
            WORD2_ADDR: v = get_byte(c.staged, word_lane(a)); // RQ6
            default: v = '0;
        endcase
        return v;
    endfunction

    logic sync_rise;
    logic req_edge;
    logic do_load;
    logic sel;

    always_comb begin
        s_d       = s_q;
        req_edge  = 1'b0;
        do_load   = 1'b0;
        sel       = 1'b0;
        // Three stages; a change counts once the last two agree
        s_d.sync_sh = {s_q.sync_sh[1:0], sync_ref_in};
        if (sync_settled(s_q.sync_sh)) begin
            s_d.sync_lvl = s_q.sync_sh[2];
        end
        sync_rise = sync_settled(s_q.sync_sh) && s_q.sync_sh[2] && !s_q.sync_lvl;

        if (wr_hit(reg_req_in, PAGE_ADDR)) begin
            s_d.page = reg_req_in.wdata;
        end

        for (int i = 0; i < NUM_CHANNELS; i++) begin
            s_d.ch[i].load_pulse = 1'b0;
            sel      = s_q.page[i]; // RQ10
            req_edge = 1'b0;
            if (reg_req_in.wr && sel) begin
                unique case (reg_req_in.addr)
                    CFG_ADDR: s_d.ch[i].cfg = reg_req_in.wdata & CFG_WRITE_MASK;
                    UPD_ADDR: begin
                        s_d.ch[i].sync_sel = reg_req_in.wdata[UPD_SYNC_BIT];
                        s_d.ch[i].req      = reg_req_in.wdata[UPD_REQ_BIT];
                        // Steady high writes raise no request edge
                        req_edge = reg_req_in.wdata[UPD_REQ_BIT] & ~s_q.ch[i].req; // RQ5
                    end
                    WORD0_ADDR,
                    WORD1_ADDR,
                    WORD2_ADDR: begin
                        s_d.ch[i].staged = put_byte(s_q.ch[i].staged,
                                                    word_lane(reg_req_in.addr),
                                                    reg_req_in.wdata); // RQ6
                    end
                    default: ;
                endcase
            end
            do_load = (s_q.ch[i].armed && sync_rise) || // RQ3
                      (req_edge && !reg_req_in.wdata[UPD_SYNC_BIT]);
            if (s_q.ch[i].armed && sync_rise) begin
                s_d.ch[i].armed = 1'b0;
            end
            if (req_edge) begin
                s_d.ch[i].ack   = 1'b0; // RQ13
                s_d.ch[i].armed = reg_req_in.wdata[UPD_SYNC_BIT]; // RQ3
            end
            // A completing load beats a same-cycle clear
            if (do_load) begin
                s_d.ch[i].active     = s_q.ch[i].staged;
                s_d.ch[i].ack        = 1'b1; // RQ4
                s_d.ch[i].load_pulse = 1'b1;
            end
        end

        if (reg_req_in.rd) begin
            if (rd_hit(reg_req_in, PAGE_ADDR)) begin
                s_d.rdata = s_q.page;
            end else begin
                s_d.rdata = read_chan(s_q.ch[first_sel(s_q.page)], reg_req_in.addr);
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            s_q      <= '0;
            s_q.page <= PAGE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Frequency math lives in the oscillator; it sees the word and the mode
    always_comb begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            chan_ctl_out[i].osc_enable           = s_q.ch[i].cfg[CFG_OSC_EN_BIT];
            chan_ctl_out[i].modulus_enable       = s_q.ch[i].cfg[CFG_MODULUS_BIT]; // RQ12 RQ7 RQ8
            chan_ctl_out[i].sideband_select      = s_q.ch[i].cfg[CFG_SIDEBAND_BIT]; // RQ1
            chan_ctl_out[i].dc_tone_input_enable = s_q.ch[i].cfg[CFG_DC_BIT]; // RQ2
            chan_ctl_out[i].tuning_word          = s_q.ch[i].active;
            chan_ctl_out[i].osc_reset            = s_q.ch[i].load_pulse;
        end
    end

    assign reg_rdata_out = s_q.rdata;

endmodule

/* cntc_bank_assertions.sv */
/* Port checker for the channel oscillator tuning bank.
 * Assumes a bind from the bench top and a single clock domain. */
`timescale 1ns/1ps
module cntc_bank_checker import cntc_pkg::*; #(
    parameter int NUM_CHANNELS = 3
) (
    input wire logic                          mclk_in,
    input wire logic                          resetn_in,
    input wire cntc_reg_req_s                 reg_req_in,
    input wire logic [DATA_W-1:0]             reg_rdata_out,
    input wire logic                          sync_ref_in,
    input wire cntc_chan_ctl_s [NUM_CHANNELS-1:0] chan_ctl_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // Page is internal, so a change must trace back to a config write
    wire cfg_wr = reg_req_in.wr && reg_req_in.addr == CFG_ADDR;
    a_reset_clears_all: assert property (disable iff (1'b0) !resetn_in |=>
        chan_ctl_out == '0 && reg_rdata_out == '0) else $error("outputs not cleared by reset");
    a_sideband_cause: assert property ($changed(chan_ctl_out[0].sideband_select) |->
        $past(cfg_wr) && chan_ctl_out[0].sideband_select == $past(reg_req_in.wdata[1]))
        else $error("sideband changed without matching write");
    a_dc_tone_cause: assert property ($changed(chan_ctl_out[0].dc_tone_input_enable) |->
        $past(cfg_wr) && chan_ctl_out[0].dc_tone_input_enable == $past(reg_req_in.wdata[0]))
        else $error("dc tone enable changed without matching write");
    a_modulus_cause: assert property ($changed(chan_ctl_out[0].modulus_enable) |->
        $past(cfg_wr) && chan_ctl_out[0].modulus_enable == $past(reg_req_in.wdata[2]))
        else $error("modulus enable changed without matching write");
    a_word_with_reset: assert property ($changed(chan_ctl_out[0].tuning_word) |->
        chan_ctl_out[0].osc_reset) else $error("word changed without oscillator reset");
    a_reset_pulse_once: assert property (chan_ctl_out[0].osc_reset |=>
        !chan_ctl_out[0].osc_reset) else $error("oscillator reset longer than one cycle");
    a_unmapped_zero: assert property (reg_req_in.rd && reg_req_in.addr == 12'h200 |=>
        reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_req_in.rd |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    c_load: cover property (chan_ctl_out[0].osc_reset);
    c_sync_load: cover property ($rose(sync_ref_in) ##[1:8] chan_ctl_out[0].osc_reset);
    c_cfg: cover property (cfg_wr ##1 chan_ctl_out[0].sideband_select);
endmodule

/* tb.sv */
/* Directed bench for the tuning bank: page, config, word staging, loads.
 * Assumes the checker file is compiled before this one. */
`timescale 1ns/1ps
module tb;
    import cntc_pkg::*;
    logic              mclk_in = 1'b0;
    logic              resetn_in = 1'b0;
    logic              sync_ref_in = 1'b0;
    cntc_reg_req_s     req = '0;
    logic [DATA_W-1:0] rdata;
    cntc_chan_ctl_s [2:0] ctl;
    int                mismatches = 0;
    int                check_count = 0;
    int                cycles = 0;
    cntc_bank #(.NUM_CHANNELS(3)) cntc_bank_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .reg_req_in(req), .reg_rdata_out(rdata), .sync_ref_in(sync_ref_in), .chan_ctl_out(ctl));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One access, strobe dropped on the edge that takes it
    task automatic acc(input logic [11:0] a, input logic [7:0] d, input logic w);
        @(posedge mclk_in);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge mclk_in);
        req <= '0;
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        forever #4 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge mclk_in);
        resetn_in <= 1'b1;
        acc(PAGE_ADDR, 8'h00, 1'b0);
        chk(rdata, 8'hff);
        acc(PAGE_ADDR, 8'h01, 1'b1);
        acc(CFG_ADDR, 8'hff, 1'b1);
        acc(CFG_ADDR, 8'h00, 1'b0);
        chk(rdata, 8'h7f);
        chk({ctl[0].sideband_select, ctl[0].dc_tone_input_enable, ctl[0].modulus_enable}, 7);
        chk(ctl[0].osc_enable, 1);
        chk(ctl[1], 0);
        acc(CFG_ADDR, 8'h02, 1'b1);
        chk({ctl[0].sideband_select, ctl[0].dc_tone_input_enable, ctl[0].modulus_enable}, 4);
        acc(PAGE_ADDR, 8'h06, 1'b1);
        acc(CFG_ADDR, 8'h41, 1'b1);
        chk({ctl[2].osc_enable, ctl[1].dc_tone_input_enable, ctl[0].osc_enable}, 6);
        acc(CFG_ADDR, 8'h00, 1'b0);
        chk(rdata, 8'h41);
        acc(PAGE_ADDR, 8'h01, 1'b1);
        $display("test config done");
        acc(WORD0_ADDR, 8'h11, 1'b1);
        acc(WORD1_ADDR, 8'h22, 1'b1);
        acc(WORD2_ADDR, 8'h33, 1'b1);
        chk(ctl[0].tuning_word, 0);
        acc(WORD1_ADDR, 8'h00, 1'b0);
        chk(rdata, 8'h22);
        acc(UPD_ADDR, 8'h01, 1'b1);
        chk({ctl[0].osc_reset, ctl[0].tuning_word}, 32'h1332211);
        acc(UPD_ADDR, 8'h00, 1'b0);
        chk(rdata, 8'h03);
        acc(WORD0_ADDR, 8'h44, 1'b1);
        acc(UPD_ADDR, 8'h01, 1'b1);
        chk(ctl[0].tuning_word, 32'h332211);
        $display("test load done");
        acc(UPD_ADDR, 8'h04, 1'b1);
        acc(UPD_ADDR, 8'h05, 1'b1);
        acc(UPD_ADDR, 8'h00, 1'b0);
        chk(rdata, 8'h05);
        @(posedge mclk_in) sync_ref_in <= 1'b1;
        // Bounded wait covers the pin synchroniser delay
        repeat (8) begin
            @(posedge mclk_in);
            #1;
            if (ctl[0].osc_reset === 1'b1) break;
        end
        chk({ctl[0].osc_reset, ctl[0].tuning_word}, 32'h1332244);
        acc(UPD_ADDR, 8'h00, 1'b0);
        chk(rdata, 8'h07);
        acc(12'h200, 8'h00, 1'b0);
        chk(rdata, 8'h00);
        $display("test sync done");
        finish_test();
    end
endmodule
bind cntc_bank cntc_bank_checker #(.NUM_CHANNELS(NUM_CHANNELS)) cntc_bank_checker_inst (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .sync_ref_in(sync_ref_in), .chan_ctl_out(chan_ctl_out));
